// File: hw/bpc_map.vh
// bpc_map.vh: offsets, field positions, reset values and timings in microseconds of the burst and protection control.
// assumes a 125 MHz pclk; included by bare name from the design files.
`ifndef BPC_MAP_VH
`define BPC_MAP_VH

// timebase
`define BPC_CLK_MHZ 125
// basic blanking, us
`define BPC_T_BLANK_US 20000
// spike filter, us
`define BPC_T_SPIKE_US 30
// supply over-voltage persistence (120+30), us
`define BPC_T_OV_US 150
// supply under-voltage persistence (10 ms + 30 us), us
`define BPC_T_UV_US 10030
// external restart-enable ignore window, us
`define BPC_T_EXT_IGN_US 1000
// soft-start period, us
`define BPC_T_SOFT_US 20000

// register byte offsets
`define BPC_REG_CTRL 12'h000
`define BPC_REG_STATUS 12'h004
`define BPC_REG_CAUSE 12'h008

// control field positions and reset value
`define BPC_CTRL_BURST_ALLOW 0
`define BPC_CTRL_EXT_ALLOW 1
`define BPC_CTRL_RESET 2'h3

// status field positions
`define BPC_ST_STATE_LSB 0
`define BPC_ST_BURST 3
`define BPC_ST_BIAS 4
`define BPC_ST_CLAMP 5
`define BPC_ST_GATE 6
`define BPC_ST_SWITCH 7

// cause field positions
`define BPC_CA_OV_SOFT 0
`define BPC_CA_OV 1
`define BPC_CA_OT 2
`define BPC_CA_OL 3
`define BPC_CA_UV 4
`define BPC_CA_EXT 5
`define BPC_CA_RESET 6'h00

`endif

// File: hw/bpc_sync.v
// bpc_sync.v: two-flop synchroniser for a group of asynchronous comparator flags.
// assumes inputs are unrelated to pclk; outputs are only valid after the second flop.
`timescale 1ns/100ps
module bpc_sync #(
   parameter W = 10
) (
   input wire pclk,
   input wire presetn,
   input wire [W-1:0] async_in,
   output wire [W-1:0] sync_out
);
   genvar i;
   // one pair of flops per bit
   generate
      for (i = 0; i < W; i = i + 1) begin : g_bit
         reg meta; // first stage, read only by the second
         reg held; // second stage
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               meta <= 1'b0;
               held <= 1'b0;
            end else begin
               meta <= async_in[i];
               held <= meta;
            end
         end
         assign sync_out[i] = held;
      end
   endgenerate
endmodule

// File: hw/bpc_filter.v
// bpc_filter.v: persistence timer; done rises once level has been high for LIMIT consecutive cycles.
// assumes level is already synchronous to pclk; level low restarts the count.
`timescale 1ns/100ps
module bpc_filter #(
   parameter [31:0] LIMIT = 32'h0000_0004
) (
   input wire pclk,
   input wire presetn,
   input wire level,
   output wire done
);
   reg [31:0] cnt; // consecutive high cycles, saturating at LIMIT

   // count while high, hold at limit, clear when low
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 32'h0000_0000;
      end else if (!level) begin
         cnt <= 32'h0000_0000;
      end else if (cnt != LIMIT) begin
         cnt <= cnt + 32'h0000_0001;
      end
   end

   assign done = (cnt == LIMIT);
endmodule

// File: hw/bpc_ctrl.v
// bpc_ctrl.v: burst-mode and auto-restart control unit of a flyback controller, with an APB register slave.
// assumes comparator flags arrive asynchronously and the power stage obeys the bias and switch outputs.
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/100ps
`include "bpc_map.vh"
module bpc_ctrl #(
   parameter [31:0] BLANK_CYC = `BPC_T_BLANK_US * `BPC_CLK_MHZ,
   parameter [31:0] OV_CYC = `BPC_T_OV_US * `BPC_CLK_MHZ,
   parameter [31:0] UV_CYC = `BPC_T_UV_US * `BPC_CLK_MHZ,
   parameter [31:0] EXT_IGN_CYC = `BPC_T_EXT_IGN_US * `BPC_CLK_MHZ,
   parameter [31:0] SOFT_CYC = `BPC_T_SOFT_US * `BPC_CLK_MHZ
) (
   input wire pclk,
   input wire presetn,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   // comparator flags, asynchronous
   input wire fb_low,
   input wire fb_burst_on,
   input wire burst_low_comparator,
   input wire feedback_high_comparator,
   input wire vcc_ov_soft,
   input wire vcc_ov,
   input wire vcc_uv,
   input wire vcc_on,
   input wire over_temp,
   input wire ext_pin_high,
   input wire ext_pin_low,
   // power stage controls
   output reg burst_flag,
   output reg bias_on,
   output reg switching_en,
   output reg low_limit_sel,
   output reg startup_cell_en,
   output reg clamp_release_switch,
   output reg restart_gate,
   output reg auto_restart,
   output reg soft_start_active
);
   // spike filter is short enough to stay a fixed count
   localparam [31:0] SPIKE_CYC = `BPC_T_SPIKE_US * `BPC_CLK_MHZ;

   // control states
   localparam [2:0] ST_OFF = 3'h0; // waiting for first turn-on
   localparam [2:0] ST_SOFT = 3'h1; // soft start
   localparam [2:0] ST_RUN = 3'h2; // normal operation
   localparam [2:0] ST_BURST = 3'h3; // active burst mode
   localparam [2:0] ST_AR_DROP = 3'h4; // restart, supply falling
   localparam [2:0] ST_AR_CHG = 3'h5; // restart, supply recharging

   wire [10:0] flags_s; // synchronised comparator flags
   wire fb_low_s = flags_s[0]; // feedback below burst entry level
   wire fb_on_s = flags_s[1]; // feedback above upper burst level
   wire fb_off_s = flags_s[2]; // feedback at lower burst level
   wire fb_high_s = flags_s[3]; // feedback above high level
   wire ov_soft_s = flags_s[4]; // supply above soft-start limit
   wire ov_s = flags_s[5]; // supply above over-voltage limit
   wire uv_s = flags_s[6]; // supply below turn-off
   wire on_s = flags_s[7]; // supply above turn-on
   wire ot_s = flags_s[8]; // overtemperature
   wire pin_high_s = flags_s[9]; // blanking pin charged
   wire pin_low_s = flags_s[10]; // blanking pin pulled low

   reg [2:0] state; // current control state
   reg [2:0] next_state;
   reg next_bias; // next internal bias
   reg [1:0] ctrl; // software control bits
   reg [5:0] cause; // sticky restart causes
   reg [31:0] soft_cnt; // cycles since soft start began
   wire active; // controller is switching or may switch
   wire soft_done;
   wire ext_armed; // ignore window over
   wire burst_blank_done;
   wire ol_blank_done;
   wire gate_done;
   wire ov_soft_done;
   wire ov_done;
   wire ot_done;
   wire uv_done;
   wire ext_done;
   wire [5:0] fault; // qualified faults this cycle
   wire any_fault;
   wire next_clamp;
   wire wr_en;
   wire rd_en;
   wire hit_ctrl;
   wire hit_status;
   wire hit_cause;

   // all comparator flags pass two flops first
   bpc_sync #(
      .W(11)
   ) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in({ext_pin_low, ext_pin_high, over_temp, vcc_on, vcc_uv, vcc_ov, vcc_ov_soft,
                 feedback_high_comparator, burst_low_comparator, fb_burst_on, fb_low}),
      .sync_out(flags_s)
   );

   assign active = (state == ST_SOFT) || (state == ST_RUN) || (state == ST_BURST);

   // soft-start and ignore-window timer, restarted on every entry to soft start
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         soft_cnt <= 32'h0000_0000;
      end else if (!active) begin
         soft_cnt <= 32'h0000_0000; // rerun at each attempt
      end else if (soft_cnt != SOFT_CYC) begin
         soft_cnt <= soft_cnt + 32'h0000_0001;
      end
   end
   assign soft_done = (soft_cnt >= SOFT_CYC);
   assign ext_armed = (soft_cnt >= EXT_IGN_CYC);

   // burst blanking: zero unless running with feedback low, basic interval only
   bpc_filter #(
      .LIMIT(BLANK_CYC)
   ) u_burst_blank (
      .pclk(pclk),
      .presetn(presetn),
      .level((state == ST_RUN) && fb_low_s && ctrl[`BPC_CTRL_BURST_ALLOW]),
      .done(burst_blank_done)
   );

   // overload blanking starts when feedback exceeds the high level
   bpc_filter #(
      .LIMIT(BLANK_CYC)
   ) u_ol_blank (
      .pclk(pclk),
      .presetn(presetn),
      .level(((state == ST_SOFT) || (state == ST_RUN)) && fb_high_s),
      .done(ol_blank_done)
   );

   // clamp released after basic blanking so the pin may charge
   assign next_clamp = ol_blank_done;

   // gate output then spike filter before restart
   bpc_filter #(
      .LIMIT(SPIKE_CYC)
   ) u_gate_filt (
      .pclk(pclk),
      .presetn(presetn),
      .level(clamp_release_switch && pin_high_s && active),
      .done(gate_done)
   );

   // soft-start over-voltage together with feedback high
   bpc_filter #(
      .LIMIT(SPIKE_CYC)
   ) u_ovs_filt (
      .pclk(pclk),
      .presetn(presetn),
      .level(active && !soft_done && ov_soft_s && fb_high_s),
      .done(ov_soft_done)
   );

   // supply over-voltage, masked in burst
   bpc_filter #(
      .LIMIT(OV_CYC)
   ) u_ov_filt (
      .pclk(pclk),
      .presetn(presetn),
      .level(active && (state != ST_BURST) && ov_s),
      .done(ov_done)
   );

   // overtemperature
   bpc_filter #(
      .LIMIT(SPIKE_CYC)
   ) u_ot_filt (
      .pclk(pclk),
      .presetn(presetn),
      .level(active && ot_s),
      .done(ot_done)
   );

   // under-voltage or shorted optocoupler
   bpc_filter #(
      .LIMIT(UV_CYC)
   ) u_uv_filt (
      .pclk(pclk),
      .presetn(presetn),
      .level(active && uv_s),
      .done(uv_done)
   );

   // external restart request, ignored early after start
   bpc_filter #(
      .LIMIT(SPIKE_CYC)
   ) u_ext_filt (
      .pclk(pclk),
      .presetn(presetn),
      .level(active && ext_armed && pin_low_s && ctrl[`BPC_CTRL_EXT_ALLOW]),
      .done(ext_done)
   );

   // faults other than the overload gate bypass the basic blanking
   assign fault = {ext_done, uv_done, gate_done, ot_done, ov_done, ov_soft_done};
   assign any_fault = |fault;

   // state and bias transitions
   always @* begin
      next_state = state;
      next_bias = bias_on;
      case (state)
         ST_OFF: begin
            next_bias = 1'b0;
            if (on_s) begin
               next_state = ST_SOFT;
               next_bias = 1'b1;
            end
         end
         ST_SOFT: begin
            if (any_fault) begin
               next_state = ST_AR_DROP;
               next_bias = 1'b0;
            end else if (soft_done) begin
               next_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (any_fault) begin
               next_state = ST_AR_DROP;
               next_bias = 1'b0;
            end else if (burst_blank_done) begin
               next_state = ST_BURST;
               next_bias = 1'b0;
            end
         end
         ST_BURST: begin
            if (any_fault) begin
               next_state = ST_AR_DROP;
               next_bias = 1'b0;
            end else if (fb_high_s) begin
               next_state = ST_RUN;
               next_bias = 1'b1;
            end else if (!bias_on && fb_on_s) begin
               next_bias = 1'b1;
            end else if (bias_on && fb_off_s) begin
               next_bias = 1'b0;
            end
         end
         ST_AR_DROP: begin
            next_bias = 1'b0;
            if (uv_s) begin
               next_state = ST_AR_CHG; // supply at turn-off
            end
         end
         ST_AR_CHG: begin
            next_bias = 1'b0;
            if (on_s && !uv_s) begin
               next_state = ST_SOFT; // recharged, rerun soft start
               next_bias = 1'b1;
            end
         end
         default: begin
            next_state = ST_OFF;
            next_bias = 1'b0;
         end
      endcase
   end

   // state and registered power-stage outputs
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ST_OFF;
         bias_on <= 1'b0;
         burst_flag <= 1'b0;
         switching_en <= 1'b0;
         low_limit_sel <= 1'b0;
         startup_cell_en <= 1'b1;
         clamp_release_switch <= 1'b0;
         restart_gate <= 1'b0;
         auto_restart <= 1'b0;
         soft_start_active <= 1'b0;
      end else begin
         state <= next_state;
         bias_on <= next_bias;
         burst_flag <= (next_state == ST_BURST);
         switching_en <= next_bias; // bias gates the pulses
         low_limit_sel <= (next_state == ST_BURST);
         // cell charges only while off or recharging, never in burst
         startup_cell_en <= (next_state == ST_OFF) || (next_state == ST_AR_CHG);
         clamp_release_switch <= next_clamp;
         restart_gate <= next_clamp && pin_high_s;
         auto_restart <= (next_state == ST_AR_DROP) || (next_state == ST_AR_CHG);
         soft_start_active <= (next_state == ST_SOFT);
      end
   end

   // apb decode; slave answers with no wait states
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && !pwrite;
   assign hit_ctrl = (paddr == `BPC_REG_CTRL);
   assign hit_status = (paddr == `BPC_REG_STATUS);
   assign hit_cause = (paddr == `BPC_REG_CAUSE);
   assign pready = 1'b1;
   assign pslverr = psel && penable && !(hit_ctrl || hit_status || hit_cause);

   // control register write
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= `BPC_CTRL_RESET;
      end else if (wr_en && hit_ctrl) begin
         ctrl <= pwdata[1:0];
      end
   end

   // sticky cause bits, write one to clear, a new fault wins
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cause <= `BPC_CA_RESET;
      end else if (wr_en && hit_cause) begin
         cause <= (cause & ~pwdata[5:0]) | fault;
      end else begin
         cause <= cause | fault;
      end
   end

   // read data registered in the setup phase
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd_en && !penable) begin
         if (hit_ctrl) begin
            prdata <= {30'h0000_0000, ctrl};
         end else if (hit_status) begin
            prdata <= {24'h00_0000, switching_en, restart_gate, clamp_release_switch, bias_on,
                       burst_flag, state};
         end else if (hit_cause) begin
            prdata <= {26'h000_0000, cause};
         end else begin
            prdata <= 32'h0000_0000; // unmapped reads as zero
         end
      end
   end
endmodule

// File: testbench/bpc_ctrl_monitor.sv
// bpc_ctrl_monitor.sv: port-level checks on the burst and protection control.
// assumes it is bound into bpc_ctrl, with its counts handed on by the bind.
`timescale 1ns/100ps
module bpc_ctrl_monitor #(
   parameter [31:0] BLANK_CYC = 32'h0000_00c8,
   parameter [31:0] SOFT_CYC = 32'h0000_0064
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pslverr,
   input wire fb_low,
   input wire feedback_high_comparator,
   input wire ext_pin_high,
   input wire burst_flag,
   input wire bias_on,
   input wire switching_en,
   input wire low_limit_sel,
   input wire startup_cell_en,
   input wire clamp_release_switch,
   input wire restart_gate,
   input wire auto_restart,
   input wire soft_start_active
);
   // run lengths of raw low feedback, raw high feedback, soft start
   logic [31:0] lo_cnt;
   logic [31:0] hi_cnt;
   logic [31:0] ss_cnt;
   // raw flags lead the synced ones, so these counts are upper bounds
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lo_cnt <= 32'h0;
         hi_cnt <= 32'h0;
         ss_cnt <= 32'h0;
      end else begin
         lo_cnt <= fb_low ? lo_cnt + 32'h1 : 32'h0;
         hi_cnt <= feedback_high_comparator ? hi_cnt + 32'h1 : 32'h0;
         ss_cnt <= soft_start_active ? ss_cnt + 32'h1 : 32'h0;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_BURST_ENTRY: assert property ($rose(burst_flag) |-> lo_cnt >= BLANK_CYC)
      else $error("burst entered before blanking");
   AST_BURST_BIAS: assert property ($rose(burst_flag) |-> !bias_on)
      else $error("bias on at burst entry");
   AST_BURST_STARTUP: assert property (burst_flag |-> !startup_cell_en)
      else $error("startup cell on in burst");
   AST_BURST_LIMIT: assert property (burst_flag |-> low_limit_sel)
      else $error("full limit in burst");
   AST_BURST_EXIT: assert property ((burst_flag && feedback_high_comparator) ##1 feedback_high_comparator [*3] |-> ##[0:2] !burst_flag)
      else $error("burst kept with feedback high");
   AST_CLAMP_BLANK: assert property ($rose(clamp_release_switch) |-> hi_cnt >= BLANK_CYC)
      else $error("clamp released early");
   AST_GATE: assert property (restart_gate |-> clamp_release_switch)
      else $error("gate open with clamp shut");
   // pin charged for four samples with the clamp open must have opened the gate
   AST_GATE_OPEN: assert property ((clamp_release_switch && ext_pin_high) [*4] |-> restart_gate)
      else $error("gate shut with pin charged");
   AST_AR_SW: assert property (auto_restart |-> !switching_en)
      else $error("switching in restart");
   AST_SOFT: assert property (ss_cnt <= SOFT_CYC + 32'h1)
      else $error("soft start too long");
   AST_PSLV: assert property (pslverr |-> psel && penable)
      else $error("error outside access");
endmodule
bind bpc_ctrl bpc_ctrl_monitor #(.BLANK_CYC(BLANK_CYC), .SOFT_CYC(SOFT_CYC)) u_bpc_ctrl_monitor (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pslverr(pslverr), .fb_low(fb_low),
   .feedback_high_comparator(feedback_high_comparator), .ext_pin_high(ext_pin_high), .burst_flag(burst_flag),
   .bias_on(bias_on), .switching_en(switching_en), .low_limit_sel(low_limit_sel),
   .startup_cell_en(startup_cell_en), .clamp_release_switch(clamp_release_switch),
   .restart_gate(restart_gate), .auto_restart(auto_restart), .soft_start_active(soft_start_active));

// File: testbench/bpc_plant.sv
// bpc_plant.sv: behavioural comparators and blanking pin facing the control unit.
// assumes levels in millivolts from the bench; flags move just after pclk edges.
`timescale 1ns/100ps
module bpc_plant #(
   parameter [15:0] VON = 16'h3a98,
   parameter [15:0] CHG = 16'h0032
) (
   input wire pclk,
   input wire [15:0] fb,
   input wire [15:0] vcc,
   input wire hot,
   input wire pull_lo,
   input wire clamp_release_switch,
   output logic [10:0] flags
);
   // blanking pin level, mV
   logic [15:0] pin = 16'h0384;
   initial flags = 11'h000;
   // pin pull-down, clamp and capacitor charge
   always @(posedge pclk) begin
      if (pull_lo) begin
         pin <= 16'h00c8;
      end else if (clamp_release_switch !== 1'b1) begin
         pin <= 16'h0384;
      end else if (pin < 16'h1004) begin
         pin <= pin + 16'h0c80 / CHG + 16'h0001;
      end
   end
   // one comparator per threshold
   always @(posedge pclk) begin
      flags <= {pin < 16'h014a, pin > 16'h0fa0, hot, vcc > VON, vcc < 16'h2904, vcc > 16'h639c,
         vcc > 16'h5014, fb > 16'h0fa0, fb <= 16'h0bb8, fb > 16'h0dac, fb < 16'h0546};
   end
endmodule

// File: testbench/bpc_ctrl_tb.sv
// bpc_ctrl_tb.sv: self-checking bench for the burst and protection control.
// assumes bpc_plant as far side; long counts shortened by parameter.
`timescale 1ns/100ps
`define CHK(a,b,m) begin compares++; if ((a) !== (b)) begin err_count++; $display("wrong value at %0t: %s", $time, m); end end
`define WT(c,n) begin k = 0; while (((c) !== 1'b1) && k < (n)) begin @(posedge pclk); k++; end if ((c) !== 1'b1) begin err_count++; $display("wrong value at %0t: wait ran out", $time); conclude; end end
module bpc_ctrl_tb;
   localparam [31:0] BLANK = 32'h0000_00c8;
   localparam [31:0] OV = 32'h0000_0028;
   localparam [31:0] UV = 32'h0000_003c;
   localparam [31:0] SOFT = 32'h0000_0fa0;
   localparam [31:0] SPIKE = 32'h0000_0ea6;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   wire [31:0] prdata;
   wire pready, pslverr;
   wire fb_low, fb_burst_on, burst_low_comparator, feedback_high_comparator, vcc_ov_soft, vcc_ov;
   wire vcc_uv, vcc_on, over_temp, ext_pin_high, ext_pin_low;
   wire burst_flag, bias_on, switching_en, low_limit_sel, startup_cell_en;
   wire clamp_release_switch, restart_gate, auto_restart, soft_start_active;
   wire [10:0] flags;
   // analog levels in mV
   logic [15:0] fb = 16'h0000;
   logic [15:0] vcc = 16'h0000;
   logic hot = 1'b0;
   logic pull_lo = 1'b0;
   logic [31:0] q;
   logic err;
   int k, err_count, compares;
   bpc_ctrl #(.BLANK_CYC(BLANK), .OV_CYC(OV), .UV_CYC(UV), .EXT_IGN_CYC(32'h0000_001e), .SOFT_CYC(SOFT)) u_bpc_ctrl (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .fb_low(fb_low),
      .fb_burst_on(fb_burst_on), .burst_low_comparator(burst_low_comparator),
      .feedback_high_comparator(feedback_high_comparator), .vcc_ov_soft(vcc_ov_soft), .vcc_ov(vcc_ov),
      .vcc_uv(vcc_uv), .vcc_on(vcc_on), .over_temp(over_temp), .ext_pin_high(ext_pin_high),
      .ext_pin_low(ext_pin_low), .burst_flag(burst_flag), .bias_on(bias_on), .switching_en(switching_en),
      .low_limit_sel(low_limit_sel), .startup_cell_en(startup_cell_en),
      .clamp_release_switch(clamp_release_switch), .restart_gate(restart_gate), .auto_restart(auto_restart),
      .soft_start_active(soft_start_active));
   bpc_plant u_bpc_plant (.pclk(pclk), .fb(fb), .vcc(vcc), .hot(hot), .pull_lo(pull_lo),
      .clamp_release_switch(clamp_release_switch), .flags(flags));
   assign {ext_pin_low, ext_pin_high, over_temp, vcc_on, vcc_uv, vcc_ov, vcc_ov_soft,
      feedback_high_comparator, burst_low_comparator, fb_burst_on, fb_low} = flags;
   // 125 MHz clock
   initial begin
      forever #4 pclk = ~pclk;
   end
   // one apb transfer, setup then access until pready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      // access phase lasts until pready is seen high at a rising edge
      do begin
         @(posedge pclk);
         k++;
      end while ((pready !== 1'b1) && (k < 16));
      if (pready !== 1'b1) begin
         err_count++;
         $display("wrong value at %0t: no ready", $time);
         conclude;
      end
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // supply collapse and recharge back through soft start
   task recover;
      @(posedge pclk);
      vcc <= 16'h2328;
      `WT(startup_cell_en, 8'h40)
      @(posedge pclk);
      vcc <= 16'h4650;
      `WT(soft_start_active, 8'h20)
      `CHK(auto_restart, 1'b0, "restart kept")
      `WT(!soft_start_active, SOFT + 32'h40)
   endtask
   task t_reset;
      `CHK(startup_cell_en, 1'b1, "startup cell")
      apb(1'b0, 12'h000, 32'h0);
      `CHK(q, 32'h3, "ctrl reset")
      apb(1'b0, 12'h008, 32'h0);
      `CHK(q, 32'h0, "cause reset")
      apb(1'b0, 12'h00c, 32'h0);
      `CHK(err, 1'b1, "unmapped")
      @(posedge pclk);
      vcc <= 16'h4650;
      `WT(soft_start_active, 8'h10)
      `CHK(startup_cell_en, 1'b0, "cell off")
      repeat (SOFT - 32'h20) @(posedge pclk);
      `CHK(soft_start_active, 1'b1, "soft short")
      `WT(!soft_start_active, 8'h40)
      `CHK(switching_en, 1'b1, "no switching")
      $display("done: reset and start");
   endtask
   task t_burst;
      fb <= 16'h03e8;
      repeat (BLANK - 32'h32) @(posedge pclk);
      fb <= 16'h07d0;
      repeat (8'h10) @(posedge pclk);
      `CHK(burst_flag, 1'b0, "burst early")
      fb <= 16'h03e8;
      repeat (BLANK - 32'h2) @(posedge pclk);
      `CHK(burst_flag, 1'b0, "burst early")
      `WT(burst_flag, 8'h10)
      `CHK(bias_on, 1'b0, "bias")
      `CHK(low_limit_sel, 1'b1, "limit")
      `CHK(startup_cell_en, 1'b0, "cell")
      apb(1'b0, 12'h004, 32'h0);
      `CHK(q[7:3], 5'h01, "status")
      vcc <= 16'h6590;
      repeat (OV + 32'h10) @(posedge pclk);
      `CHK(auto_restart, 1'b0, "ov in burst")
      vcc <= 16'h4650;
      fb <= 16'h0e10;
      `WT(bias_on, 8'h10)
      fb <= 16'h0b54;
      `WT(!bias_on, 8'h10)
      fb <= 16'h1068;
      `WT(!burst_flag, 8'h10)
      `CHK(low_limit_sel, 1'b0, "limit kept")
      fb <= 16'h07d0;
      $display("done: burst");
   endtask
   task t_ov;
      vcc <= 16'h6590;
      repeat (OV) @(posedge pclk);
      `CHK(auto_restart, 1'b0, "ov early")
      `WT(auto_restart, 8'h10)
      vcc <= 16'h4650;
      apb(1'b0, 12'h008, 32'h0);
      `CHK(q[1], 1'b1, "ov cause")
      apb(1'b1, 12'h008, 32'h2);
      apb(1'b0, 12'h008, 32'h0);
      `CHK(q, 32'h0, "cause clear")
      recover;
      $display("done: over-voltage");
   endtask
   task t_ovl;
      fb <= 16'h1068;
      repeat (BLANK - 32'h4) @(posedge pclk);
      `CHK(clamp_release_switch, 1'b0, "clamp early")
      `WT(clamp_release_switch, 8'h10)
      `CHK(restart_gate, 1'b0, "gate early")
      `WT(restart_gate, 8'h50)
      repeat (SPIKE - 32'h20) @(posedge pclk);
      `CHK(auto_restart, 1'b0, "filter short")
      `WT(auto_restart, 8'h40)
      fb <= 16'h07d0;
      recover;
      hot <= 1'b1;
      repeat (SPIKE - 32'h20) @(posedge pclk);
      `CHK(auto_restart, 1'b0, "ot early")
      `WT(auto_restart, 8'h40)
      hot <= 1'b0;
      recover;
      $display("done: overload and temperature");
   endtask
   task t_ext;
      apb(1'b1, 12'h000, 32'h1);
      apb(1'b0, 12'h000, 32'h0);
      `CHK(q, 32'h1, "ctrl readback")
      pull_lo <= 1'b1;
      repeat (SPIKE + 32'h40) @(posedge pclk);
      `CHK(auto_restart, 1'b0, "ext disabled")
      apb(1'b1, 12'h000, 32'h3);
      `WT(auto_restart, 16'h1000)
      pull_lo <= 1'b0;
      recover;
      vcc <= 16'h2328;
      repeat (UV - 32'h4) @(posedge pclk);
      `CHK(startup_cell_en, 1'b0, "uv early")
      `WT(startup_cell_en, 8'h10)
      vcc <= 16'h5208;
      fb <= 16'h1068;
      `WT(soft_start_active, 8'h20)
      `WT(auto_restart, SPIKE + 32'h20)
      apb(1'b0, 12'h008, 32'h0);
      `CHK(q[0], 1'b1, "soft ov cause")
      fb <= 16'h07d0;
      recover;
      $display("done: external, under-voltage, soft over-voltage");
   endtask
   task conclude;
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // reset held 16 cycles, then the scenarios
   initial begin
      repeat (8'h10) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_burst;
      t_ov;
      t_ovl;
      t_ext;
      conclude;
   end
endmodule
